// *** pkg/adcc_pkg.sv ***
package adcc_pkg;
   // register location and reset value
   localparam logic [7:0] CTRL_ADDR = 8'hD8;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // field positions inside the control register
   localparam int FLAG_BIT = 7;
   localparam int DMA_BIT = 6;
   localparam int CONT_BIT = 5;
   localparam int SINGLE_BIT = 4;
   localparam int CS_LSB = 0;
   localparam int CS_W = 4;
   // channel codes
   localparam logic [3:0] CH_TEMP = 4'h8;
   localparam logic [3:0] CH_OUT0 = 4'h9;
   localparam logic [3:0] CH_OUT1 = 4'hA;
   localparam logic [3:0] CH_AGND = 4'hB;
   localparam logic [3:0] CH_REF = 4'hC;
   localparam logic [3:0] CH_STOP = 4'hF;
   // result path
   localparam int RES_W = 12;
   localparam int FIFO_W = 16;
   localparam int FIFO_D = 16;
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_START = 2'b10,
      ST_WAIT = 2'b11
   } adcc_state_t;
endpackage : adcc_pkg

// *** rtl/adcc_ctrl.sv ***
// How it works
// - non-DMA conversion end or DMA stop code sets done flag bit 7
// - interrupt vectoring clears the done flag
// - writing bit 6 enables DMA capture
// - DMA bit self-clears when capture finishes
// - DMA bit stops strobe until capture starts
// - bit 5 restarts conversions back to back
// - bit 4 starts one conversion, self-clears
// - non-DMA conversions use channel bits 3:0
// - DMA conversions take channel from memory
// - register at D8, resets zero, bit addressable
// - channel codes decode; all ones ends DMA
`timescale 1ns/1ns
`default_nettype none
module adcc_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata_q,
   input wire logic [7:0] bit_addr,
   input wire logic bit_wr,
   input wire logic bit_wdata,
   // interrupt vector taken
   input wire logic int_ack,
   output logic conversion_done_flag_q,
   // converter core
   output logic conv_start_q,
   output logic [3:0] conv_channel_q,
   output logic conv_aux_q,
   input wire logic conv_done,
   input wire logic [11:0] conv_result,
   // channel ids from memory
   input wire logic dma_ch_valid,
   input wire logic [3:0] dma_ch_id,
   output logic dma_ch_ready_q,
   // address latch strobe gate
   output logic ale_enable_q,
   // results out
   input wire logic result_ready,
   output logic result_valid,
   output logic [15:0] result_data
);
   localparam int FB = adcc_pkg::FLAG_BIT;
   localparam int DB = adcc_pkg::DMA_BIT;
   localparam int CB = adcc_pkg::CONT_BIT;
   localparam int SB = adcc_pkg::SINGLE_BIT;

   // all ones marks end of a capture list
   function automatic logic is_stop(input logic [3:0] id);
      is_stop = (id == adcc_pkg::CH_STOP);
   endfunction : is_stop

   // codes eight to twelve route internal sources
   function automatic logic is_aux(input logic [3:0] id);
      is_aux = (id >= adcc_pkg::CH_TEMP) && (id <= adcc_pkg::CH_REF);
   endfunction : is_aux

   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   adcc_pkg::adcc_state_t state_q;
   adcc_pkg::adcc_state_t state_d;
   logic dma_started_q;
   logic byte_hit;
   logic bit_hit;
   logic reg_hit;
   logic conv_end;
   logic dma_take;
   logic dma_end;
   logic start_req;
   logic fifo_in_ready;
   logic [3:0] cs_field;

   // bus decode, direct and bit addressed
   assign byte_hit = sfr_wr && (sfr_addr == adcc_pkg::CTRL_ADDR);
   assign bit_hit = bit_wr && (bit_addr[7:3] == adcc_pkg::CTRL_ADDR[7:3]);
   assign reg_hit = byte_hit || bit_hit;
   assign cs_field = ctrl_q[adcc_pkg::CS_LSB +: adcc_pkg::CS_W];

   // sequencer events
   assign conv_end = (state_q == adcc_pkg::ST_WAIT) && conv_done;
   assign dma_take = dma_ch_ready_q && dma_ch_valid;
   assign dma_end = dma_take && is_stop(dma_ch_id);
   assign start_req = ctrl_q[SB] || ctrl_q[CB];

   // control register next value, hardware set wins
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (byte_hit)
         ctrl_d = sfr_wdata;
      if (bit_hit)
         ctrl_d[bit_addr[2:0]] = bit_wdata;
      if (conv_end)
         ctrl_d[SB] = 1'b0;
      if (dma_end)
         ctrl_d[DB] = 1'b0;
      if (int_ack)
         ctrl_d[FB] = 1'b0;
      if ((conv_end && !ctrl_q[DB]) || dma_end)
         ctrl_d[FB] = 1'b1;
   end

   // control register
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ctrl_q <= adcc_pkg::CTRL_RESET;
      else
         ctrl_q <= ctrl_d;
   end

   // sequencer next state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         adcc_pkg::ST_IDLE:
            if (ctrl_q[DB])
               state_d = adcc_pkg::ST_FETCH;
            else if (start_req)
               state_d = adcc_pkg::ST_START;
         adcc_pkg::ST_FETCH:
            if (!ctrl_q[DB] || dma_end)
               state_d = adcc_pkg::ST_IDLE;
            else if (dma_take)
               state_d = adcc_pkg::ST_START;
         adcc_pkg::ST_START:
            if (fifo_in_ready)
               state_d = adcc_pkg::ST_WAIT;
         adcc_pkg::ST_WAIT:
            if (conv_done)
               state_d = ctrl_q[DB] ? adcc_pkg::ST_FETCH : adcc_pkg::ST_IDLE;
         default:
            state_d = adcc_pkg::ST_IDLE;
      endcase
   end

   // sequencer state
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         state_q <= adcc_pkg::ST_IDLE;
      else
         state_q <= state_d;
   end

   // channel latch for each conversion
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         conv_channel_q <= '0;
         conv_aux_q <= 1'b0;
      end
      else if (state_q == adcc_pkg::ST_IDLE && !ctrl_q[DB] && start_req)
      begin
         conv_channel_q <= cs_field;
         conv_aux_q <= is_aux(cs_field);
      end
      else if (state_q == adcc_pkg::ST_FETCH && dma_take && !dma_end)
      begin
         conv_channel_q <= dma_ch_id;
         conv_aux_q <= is_aux(dma_ch_id);
      end
   end

   // start pulse only when a result slot is free
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         conv_start_q <= 1'b0;
      else
         conv_start_q <= (state_q == adcc_pkg::ST_START) && fifo_in_ready;
   end

   // id request toward memory
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         dma_ch_ready_q <= 1'b0;
      else
         dma_ch_ready_q <= (state_d == adcc_pkg::ST_FETCH) && !dma_take;
   end

   // capture started marker and strobe gate
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         dma_started_q <= 1'b0;
         ale_enable_q <= 1'b1;
      end
      else
      begin
         if (!ctrl_d[DB])
            dma_started_q <= 1'b0;
         else if (dma_take)
            dma_started_q <= 1'b1;
         ale_enable_q <= !(ctrl_d[DB] && !(dma_started_q || dma_take));
      end
   end

   // register read port, unmapped reads give zero
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         sfr_rdata_q <= 8'h00;
      else if (sfr_rd && sfr_addr == adcc_pkg::CTRL_ADDR)
         sfr_rdata_q <= ctrl_q;
      else
         sfr_rdata_q <= 8'h00;
   end

   // flag copy for the interrupt controller
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         conversion_done_flag_q <= 1'b0;
      else
         conversion_done_flag_q <= ctrl_d[FB];
   end

   // result buffer, channel tag on top
   adcc_fifo #(
      .W(adcc_pkg::FIFO_W),
      .D(adcc_pkg::FIFO_D),
      .AW(4)
   ) u_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(conv_end),
      .in_data({conv_channel_q, conv_result}),
      .in_ready(fifo_in_ready),
      .out_ready(result_ready),
      .out_valid(result_valid),
      .out_data(result_data)
   );

   // checks
   sequence s_conv_end_cont;
      conv_end && ctrl_q[CB] && !ctrl_q[DB] && !reg_hit;
   endsequence
   sequence s_room_two;
      (!reg_hit && fifo_in_ready) [*2];
   endsequence

   a_done_sets_flag: assert property (@(posedge clk) disable iff (reset)
      conv_end && !ctrl_q[DB] |=> ctrl_q[FB] && conversion_done_flag_q)
      else $error("done flag not set after conversion");
   a_ack_clears_flag: assert property (@(posedge clk) disable iff (reset)
      int_ack && !conv_end && !dma_end && !reg_hit |=> !ctrl_q[FB])
      else $error("done flag not cleared by vector");
   a_dma_bit_write: assert property (@(posedge clk) disable iff (reset)
      ((byte_hit && sfr_wdata[DB] && !bit_hit) ||
      (bit_hit && bit_addr[2:0] == 3'(DB) && bit_wdata)) && !dma_end
      |=> ctrl_q[DB])
      else $error("dma bit write lost");
   a_dma_self_clear: assert property (@(posedge clk) disable iff (reset)
      dma_end |=> !ctrl_q[DB] && ctrl_q[FB] && state_q == adcc_pkg::ST_IDLE)
      else $error("dma bit not cleared at stop code");
   a_ale_gate: assert property (@(posedge clk) disable iff (reset)
      ctrl_q[DB] && !dma_started_q && !dma_take && !reg_hit && !dma_end
      |=> !ale_enable_q)
      else $error("strobe runs while dma armed");
   a_cont_restart: assert property (@(posedge clk) disable iff (reset)
      s_conv_end_cont ##1 s_room_two |=> conv_start_q)
      else $error("continuous mode did not restart");
   a_single_clear: assert property (@(posedge clk) disable iff (reset)
      conv_end && ctrl_q[SB] && !reg_hit |=> !ctrl_q[SB])
      else $error("single bit not cleared");
   a_chan_register: assert property (@(posedge clk) disable iff (reset)
      state_q == adcc_pkg::ST_IDLE && !ctrl_q[DB] && start_req
      |=> conv_channel_q == $past(cs_field))
      else $error("wrong register channel");
   a_chan_memory: assert property (@(posedge clk) disable iff (reset)
      dma_take && !dma_end |=> conv_channel_q == $past(dma_ch_id) ##1 1'b1)
      else $error("wrong memory channel");
   a_reg_read: assert property (@(posedge clk) disable iff (reset)
      sfr_rd && sfr_addr == adcc_pkg::CTRL_ADDR |=> sfr_rdata_q == $past(ctrl_q))
      else $error("register read mismatch");
endmodule : adcc_ctrl
`default_nettype wire

// *** rtl/adcc_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module adcc_fifo #(
   parameter int W = 16,
   parameter int D = 16,
   parameter int AW = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // drain side
   input wire logic out_ready,
   output logic out_valid,
   output logic [W-1:0] out_data
);
   localparam logic [AW:0] FULL = (AW+1)'(D);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic out_valid_q;
   logic [W-1:0] out_data_q;
   logic push;
   logic pop;

   // handshakes on both sides
   assign in_ready = (count_q != FULL);
   assign push = in_valid && in_ready;
   assign pop = (count_q != '0) && (!out_valid_q || out_ready);
   assign out_valid = out_valid_q;
   assign out_data = out_data_q;

   // storage, written without reset
   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wr_ptr_q] <= in_data;
   end

   // pointers and fill level
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= rd_ptr_q + 1'b1;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end

   // registered read stage
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         out_valid_q <= 1'b0;
         out_data_q <= '0;
      end
      else if (pop)
      begin
         out_valid_q <= 1'b1;
         out_data_q <= mem_q[rd_ptr_q];
      end
      else if (out_ready)
         out_valid_q <= 1'b0;
   end
endmodule : adcc_fifo
`default_nettype wire

// *** tb/adcc_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module adcc_core_model #(
   parameter int DLY = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // converter side
   input wire logic conv_start_q,
   input wire logic [3:0] conv_channel_q,
   output logic conv_done,
   output logic [11:0] conv_result
);
   int cnt_q;
   // answers each start after DLY cycles, result moves while idle
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_q <= 0;
         conv_done <= 1'b0;
         conv_result <= 12'h000;
      end
      else
      begin
         conv_done <= (cnt_q == 1);
         conv_result <= (cnt_q == 1) ? {8'h5A, conv_channel_q} : ~conv_result;
         if (conv_start_q)
            cnt_q <= DLY;
         else if (cnt_q != 0)
            cnt_q <= cnt_q - 1;
      end
   end
endmodule : adcc_core_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk, reset, sfr_wr, sfr_rd, bit_wr, bit_wdata, int_ack;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, bit_addr;
   logic flag, start, aux, done, dvalid, dready, ale, rready, rvalid;
   logic [3:0] chan, did;
   logic [11:0] res;
   logic [15:0] rdata;
   int err_total, cmp_count;
   adcc_ctrl dut (.clk(clk), .reset(reset), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
      .sfr_rdata_q(sfr_rdata_q), .bit_addr(bit_addr), .bit_wr(bit_wr),
      .bit_wdata(bit_wdata), .int_ack(int_ack),
      .conversion_done_flag_q(flag), .conv_start_q(start),
      .conv_channel_q(chan), .conv_aux_q(aux), .conv_done(done),
      .conv_result(res), .dma_ch_valid(dvalid), .dma_ch_id(did),
      .dma_ch_ready_q(dready), .ale_enable_q(ale), .result_ready(rready),
      .result_valid(rvalid), .result_data(rdata));
   adcc_core_model core (.clk(clk), .reset(reset), .conv_start_q(start),
      .conv_channel_q(chan), .conv_done(done), .conv_result(res));
   // verdict and end of run
   task automatic finish_test();
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic hang();
      err_total++;
      $display("[ERR] %0t wait ran out", $time);
      finish_test();
   endtask : hang
   task automatic wr(logic [7:0] d);
      @(posedge clk);
      sfr_addr <= adcc_pkg::CTRL_ADDR;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] exp);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1 chk(sfr_rdata_q, exp);
   endtask : rd
   task automatic bw(logic [7:0] a, logic v);
      @(posedge clk);
      bit_addr <= a;
      bit_wdata <= v;
      bit_wr <= 1'b1;
      @(posedge clk);
      bit_wr <= 1'b0;
   endtask : bw
   // waits for a start pulse and checks the channel it carries
   task automatic wait_start(logic [3:0] c);
      for (int i = 0; i < 40; i++)
      begin
         @(posedge clk);
         #1;
         if (start === 1'b1)
         begin
            chk(chan, c);
            chk(aux, c inside {[4'h8 : 4'hC]});
            return;
         end
      end
      hang();
   endtask : wait_start
   task automatic wait_flag();
      for (int i = 0; i < 40; i++)
      begin
         @(posedge clk);
         #1;
         if (flag === 1'b1)
            return;
      end
      hang();
   endtask : wait_flag
   // channel codes 0 to 12 once, results held back then drained in order
   task automatic t_single();
      int n;
      @(posedge clk);
      rready <= 1'b0;
      for (int c = 0; c <= 12; c++)
      begin
         wr(8'h10 | 8'(c));
         wait_start(4'(c));
         wait_flag();
         rd(adcc_pkg::CTRL_ADDR, 8'h80 | 8'(c));
         if (c % 2 == 0)
         begin
            @(posedge clk);
            int_ack <= 1'b1;
            @(posedge clk);
            int_ack <= 1'b0;
         end
         else
            bw(8'hDF, 1'b0);
         rd(adcc_pkg::CTRL_ADDR, 8'(c));
      end
      @(posedge clk);
      rready <= 1'b1;
      #1 n = 0;
      for (int i = 0; i < 40 && n < 13; i++)
      begin
         if (rvalid === 1'b1)
         begin
            chk(rdata, {4'(n), 8'h5A, 4'(n)});
            n++;
         end
         @(posedge clk);
         #1;
      end
      chk(16'(n), 16'd13);
   endtask : t_single
   // back to back conversions until the mode is switched off
   task automatic t_cont();
      wr(8'h21);
      for (int k = 0; k < 3; k++)
         wait_start(4'h1);
      wr(8'h01);
      rd(adcc_pkg::CTRL_ADDR, 8'h01);
      bw(8'hDF, 1'b0);
   endtask : t_cont
   // holds the id until the edge at which ready is sampled high
   task automatic offer(logic [3:0] id);
      @(posedge clk);
      dvalid <= 1'b1;
      did <= id;
      for (int i = 0; i < 40; i++)
      begin
         #1;
         if (dready === 1'b1)
         begin
            @(posedge clk);
            dvalid <= 1'b0;
            did <= ~id;
            return;
         end
         @(posedge clk);
      end
      hang();
   endtask : offer
   // capture with register channel 5 ignored, then the stop code
   task automatic t_dma();
      wr(8'h45);
      @(posedge clk);
      #1 chk(ale, 1'b0);
      offer(4'h2);
      wait_start(4'h2);
      chk(ale, 1'b1);
      for (int i = 0; i < 40; i++)
      begin
         @(posedge clk);
         #1;
         if (rvalid === 1'b1)
            break;
      end
      chk(16'(rvalid), 16'h0001);
      chk(rdata, {4'h2, 8'h5A, 4'h2});
      chk(16'(flag), 16'h0000);
      offer(adcc_pkg::CH_STOP);
      wait_flag();
      rd(adcc_pkg::CTRL_ADDR, 8'h85);
      chk(ale, 1'b1);
   endtask : t_dma
   // free running clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // main sequence
   initial
   begin
      {sfr_wr, sfr_rd, bit_wr, bit_wdata, int_ack, dvalid} = '0;
      {sfr_addr, sfr_wdata, bit_addr, did} = '0;
      rready = 1'b1;
      err_total = 0;
      cmp_count = 0;
      reset = 1'b1;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd(adcc_pkg::CTRL_ADDR, adcc_pkg::CTRL_RESET);
      chk(ale, 1'b1);
      rd(8'hD9, 8'h00);
      bw(8'hDB, 1'b1);
      rd(adcc_pkg::CTRL_ADDR, 8'h08);
      t_single();
      t_cont();
      t_dma();
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
